// File: pid_loop.v
// pid loop update engine with apb register access and scaled analog output word
// Summary of operation
// - raw 16-bit samples become reals first
// - normalise: raw over span plus offset
// - spans 32000 unipolar, 64000 bipolar
// - output: subtract bipolar offset, times span
// - round to 32-bit integer, narrow to 16
// - positive gain forward, negative gain reverse
// - zero gain: time signs set direction
// - update writes target only on an enable edge, never measured
// - output clamped to 0..1 each update
// - integral sum written back for next update unless ti is infinite
// - output above one: sum = 1-(p+d)
// - output below zero: sum = -(p+d)
// - integral sum clamped to 0..1
// - keep previous measured value, software leaves it
// - update only while enable is set
// - history bit detects enable rising edge
// - on edge copy measured and output fields
// - history set at reset and stop-to-run
// - enable already set after run: no handover
// - proportional = gain times target minus measured
// - derivative = gain*td/ts*(previous - measured)
// - zero gain uses one for i and d
// - first sample: previous equals measured
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "pid_loop_consts.vh"

module pid_loop #(
    parameter [16:0] UNI_SPAN = `PID_UNI_SPAN,  // unipolar span
    parameter [16:0] BI_SPAN  = `PID_BI_SPAN    // bipolar span
) (
    input  wire        pclk,     // apb clock
    input  wire        presetn,  // async reset, active low
    input  wire [7:0]  paddr,    // byte address
    input  wire        psel,     // slave select
    input  wire        penable,  // access phase
    input  wire        pwrite,   // write when high
    input  wire [31:0] pwdata,   // write data
    output reg  [31:0] prdata,   // read data
    output wire        pready,   // always ready
    output wire        pslverr,  // unmapped access
    output reg  [15:0] ao_word,  // analog output word
    output reg         ao_valid  // one-cycle pulse with new word
);

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_DIV   = 3'h1;
    localparam [2:0] S_CALC1 = 3'h2;
    localparam [2:0] S_CALC2 = 3'h3;
    localparam [2:0] S_CALC3 = 3'h4;
    localparam [2:0] S_OUT   = 3'h5;
    localparam [1:0] J_MEAS = 2'h0;
    localparam [1:0] J_TGT  = 2'h1;
    localparam [1:0] J_KI   = 2'h2;
    localparam [1:0] J_KD   = 2'h3;
    reg signed [31:0] meas_ff;
    reg signed [31:0] tgt_ff;
    reg signed [31:0] out_ff;
    reg signed [31:0] gain_ff;
    reg signed [31:0] ts_ff;
    reg signed [31:0] ti_ff;
    reg signed [31:0] td_ff;
    reg signed [31:0] isum_ff;
    reg signed [31:0] prev_ff;
    reg        [2:0]  ctrl_ff;
    reg               hist_ff;
    reg               first_ff;
    reg               run_q_ff;
    reg               edge_ff;
    reg               sat_hi_ff;
    reg               sat_lo_ff;
    reg        [2:0]  state_ff;
    reg        [1:0]  job_ff;
    reg        [47:0] dv_num_ff;
    reg        [31:0] dv_den_ff;
    reg        [32:0] dv_rem_ff;
    reg        [47:0] dv_q_ff;
    reg        [5:0]  dv_cnt_ff;
    reg               dv_neg_ff;
    reg signed [31:0] ki_ff;
    reg signed [31:0] kd_ff;
    reg signed [31:0] mp_ff;
    reg signed [31:0] mi_ff;
    reg signed [31:0] md_ff;
    reg signed [49:0] scal_ff;

    // q16.16 multiply, saturated to 32 bits
    function signed [31:0] qmul;
        input signed [31:0] a;
        input signed [31:0] b;
        reg signed [63:0] p;
        begin
            p = a * b;
            if (p[63:47] != {17{p[63]}})
                qmul = p[63] ? 32'sh8000_0000 : `PID_INF;
            else
                qmul = p[47:16];
        end
    endfunction
    function signed [31:0] sat32;
        input signed [33:0] v;
        begin
            if (v[33:31] != {3{v[33]}})
                sat32 = v[33] ? 32'sh8000_0000 : `PID_INF;
            else
                sat32 = v[31:0];
        end
    endfunction
    function signed [31:0] clamp01;
        input signed [33:0] v;
        begin
            if (v < 34'sh0)
                clamp01 = `PID_ZERO;
            else if (v > {{2{1'b0}}, `PID_ONE})
                clamp01 = `PID_ONE;
            else
                clamp01 = v[31:0];
        end
    endfunction
    function [31:0] mag;
        input signed [31:0] v;
        begin
            mag = v[31] ? (~v + 32'h1) : v;
        end
    endfunction
    function signed [33:0] ext34;
        input signed [31:0] v;
        begin
            ext34 = {{2{v[31]}}, v};
        end
    endfunction
    wire busy = (state_ff != S_IDLE);
    wire acc  = psel & penable;
    wire wr   = acc & pwrite & ~pslverr;
    wire go   = wr && (paddr == `PID_OFS_CTRL) && pwdata[`PID_CTRL_GO];
    wire wr_idle = wr & ~busy;
    wire               bipolar  = ctrl_ff[`PID_CTRL_BIPOLAR];
    wire               run      = ctrl_ff[`PID_CTRL_RUN];
    wire signed [31:0] offset   = bipolar ? `PID_HALF : `PID_ZERO;
    wire        [16:0] span     = bipolar ? BI_SPAN : UNI_SPAN;
    wire               ti_inf   = (ti_ff == `PID_INF);
    // zero gain falls back to one for i and d, so time signs steer the loop
    wire signed [31:0] kc_eff   = (gain_ff == `PID_ZERO) ? `PID_ONE : gain_ff;
    wire signed [31:0] err      = tgt_ff - meas_ff;
    wire signed [31:0] dmeas    = prev_ff - meas_ff;
    wire signed [33:0] pd_sum   = ext34(mp_ff) + ext34(md_ff);
    wire signed [33:0] mn_raw   = pd_sum + ext34(mi_ff);
    wire signed [31:0] mn_clamp = clamp01(mn_raw);
    wire signed [31:0] mn_off   = mn_clamp - offset;
    wire signed [49:0] scal_rnd = scal_ff + `PID_RND;
    wire signed [31:0] raw_ext  = {{16{pwdata[15]}}, pwdata[15:0]};
    // divider step
    wire [32:0] dv_sh  = {dv_rem_ff[31:0], dv_num_ff[47]};
    wire        dv_ge  = (dv_sh >= {1'b0, dv_den_ff});
    wire [47:0] dv_qn  = {dv_q_ff[46:0], dv_ge};
    wire [31:0] dv_mag = (dv_qn[47:31] != 17'h0) ? 32'h7fff_ffff : dv_qn[31:0];
    wire signed [31:0] dv_res = dv_neg_ff ? (~dv_mag + 32'h1) : dv_mag;
    reg        [31:0] rd_val;
    reg               hit;
    always @*
    begin
        hit    = 1'b1;
        rd_val = 32'h0;
        if (paddr == `PID_OFS_MEAS)
            rd_val = meas_ff;
        else if (paddr == `PID_OFS_TGT)
            rd_val = tgt_ff;
        else if (paddr == `PID_OFS_OUT)
            rd_val = out_ff;
        else if (paddr == `PID_OFS_GAIN)
            rd_val = gain_ff;
        else if (paddr == `PID_OFS_TS)
            rd_val = ts_ff;
        else if (paddr == `PID_OFS_TI)
            rd_val = ti_ff;
        else if (paddr == `PID_OFS_TD)
            rd_val = td_ff;
        else if (paddr == `PID_OFS_ISUM)
            rd_val = isum_ff;
        else if (paddr == `PID_OFS_PREV)
            rd_val = prev_ff;
        else if (paddr == `PID_OFS_CTRL)
            rd_val = {29'h0, ctrl_ff};
        else if (paddr == `PID_OFS_STAT)
            rd_val = {26'h0, sat_lo_ff, sat_hi_ff, edge_ff, first_ff, hist_ff, busy};
        else if (paddr == `PID_OFS_RAW_MEAS || paddr == `PID_OFS_RAW_TGT)
            rd_val = 32'h0;
        else if (paddr == `PID_OFS_AO)
            rd_val = {16'h0, ao_word};
        else
            hit = 1'b0;
    end
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= rd_val;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meas_ff   <= `PID_RST_REAL;
            tgt_ff    <= `PID_RST_REAL;
            out_ff    <= `PID_RST_REAL;
            gain_ff   <= `PID_RST_REAL;
            ts_ff     <= `PID_RST_REAL;
            ti_ff     <= `PID_RST_REAL;
            td_ff     <= `PID_RST_REAL;
            isum_ff   <= `PID_RST_REAL;
            prev_ff   <= `PID_RST_REAL;
            ctrl_ff   <= `PID_RST_CTRL;
            hist_ff   <= 1'b1;
            first_ff  <= 1'b1;
            run_q_ff  <= 1'b0;
            edge_ff   <= 1'b0;
            sat_hi_ff <= 1'b0;
            sat_lo_ff <= 1'b0;
            state_ff  <= S_IDLE;
            job_ff    <= J_MEAS;
            dv_num_ff <= 48'h0;
            dv_den_ff <= 32'h0;
            dv_rem_ff <= 33'h0;
            dv_q_ff   <= 48'h0;
            dv_cnt_ff <= 6'h0;
            dv_neg_ff <= 1'b0;
            ki_ff     <= `PID_RST_REAL;
            kd_ff     <= `PID_RST_REAL;
            mp_ff     <= `PID_RST_REAL;
            mi_ff     <= `PID_RST_REAL;
            md_ff     <= `PID_RST_REAL;
            scal_ff   <= 50'sh0;
            ao_word   <= 16'h0;
            ao_valid  <= 1'b0;
        end
        else
        begin
            ao_valid <= 1'b0;
            run_q_ff <= run;
            // stop-to-run rearms the history bit and the first-sample seed
            if (run && !run_q_ff)
            begin
                hist_ff  <= 1'b1;
                first_ff <= 1'b1;
            end
            if (wr && paddr == `PID_OFS_CTRL)
                ctrl_ff <= pwdata[2:0];
            // loop fields are frozen while an update runs; late writes are dropped
            if (wr_idle)
            begin
                if (paddr == `PID_OFS_MEAS)
                    meas_ff <= pwdata;
                else if (paddr == `PID_OFS_TGT)
                    tgt_ff <= pwdata;
                else if (paddr == `PID_OFS_OUT)
                    out_ff <= pwdata;
                else if (paddr == `PID_OFS_GAIN)
                    gain_ff <= pwdata;
                else if (paddr == `PID_OFS_TS)
                    ts_ff <= pwdata;
                else if (paddr == `PID_OFS_TI)
                    ti_ff <= pwdata;
                else if (paddr == `PID_OFS_TD)
                    td_ff <= pwdata;
                else if (paddr == `PID_OFS_ISUM)
                    isum_ff <= pwdata;
                else if (paddr == `PID_OFS_PREV)
                    prev_ff <= pwdata;
            end
            case (state_ff)
                S_IDLE:
                begin
                    if (wr_idle && (paddr == `PID_OFS_RAW_MEAS || paddr == `PID_OFS_RAW_TGT))
                    begin
                        // raw integer over span in a shared serial divider
                        job_ff    <= (paddr == `PID_OFS_RAW_MEAS) ? J_MEAS : J_TGT;
                        dv_num_ff <= {mag(raw_ext), 16'h0};
                        dv_den_ff <= {15'h0, span};
                        dv_neg_ff <= raw_ext[31];
                        dv_rem_ff <= 33'h0;
                        dv_q_ff   <= 48'h0;
                        dv_cnt_ff <= `PID_DIV_BITS;
                        state_ff  <= S_DIV;
                    end
                    else if (go && !busy && run)
                    begin
                        hist_ff <= pwdata[`PID_CTRL_EN];
                        edge_ff <= pwdata[`PID_CTRL_EN] & ~hist_ff;
                        if (pwdata[`PID_CTRL_EN])
                        begin
                            if (!hist_ff)
                            begin
                                tgt_ff  <= meas_ff;
                                prev_ff <= meas_ff;
                                isum_ff <= out_ff;
                            end
                            if (first_ff)
                                prev_ff <= meas_ff;
                            first_ff  <= 1'b0;
                            // ts/ti first, then td/ts; infinite ti skips the first
                            job_ff    <= ti_inf ? J_KD : J_KI;
                            ki_ff     <= `PID_ZERO;
                            dv_num_ff <= ti_inf ? {mag(td_ff), 16'h0} : {mag(ts_ff), 16'h0};
                            dv_den_ff <= ti_inf ? mag(ts_ff) : mag(ti_ff);
                            dv_neg_ff <= ti_inf ? (td_ff[31] ^ ts_ff[31]) : (ts_ff[31] ^ ti_ff[31]);
                            dv_rem_ff <= 33'h0;
                            dv_q_ff   <= 48'h0;
                            dv_cnt_ff <= `PID_DIV_BITS;
                            state_ff  <= S_DIV;
                        end
                    end
                end
                S_DIV:
                begin
                    dv_rem_ff <= dv_ge ? (dv_sh - {1'b0, dv_den_ff}) : dv_sh;
                    dv_q_ff   <= dv_qn;
                    dv_num_ff <= {dv_num_ff[46:0], 1'b0};
                    dv_cnt_ff <= dv_cnt_ff - 6'h1;
                    if (dv_cnt_ff == 6'h1)
                    begin
                        state_ff <= S_IDLE;
                        if (job_ff == J_MEAS)
                            meas_ff <= dv_res + offset;
                        else if (job_ff == J_TGT)
                            tgt_ff <= dv_res + offset;
                        else if (job_ff == J_KI)
                        begin
                            ki_ff     <= dv_res;
                            job_ff    <= J_KD;
                            dv_num_ff <= {mag(td_ff), 16'h0};
                            dv_den_ff <= mag(ts_ff);
                            dv_neg_ff <= td_ff[31] ^ ts_ff[31];
                            dv_rem_ff <= 33'h0;
                            dv_q_ff   <= 48'h0;
                            dv_cnt_ff <= `PID_DIV_BITS;
                            state_ff  <= S_DIV;
                        end
                        else
                        begin
                            kd_ff    <= dv_res;
                            state_ff <= S_CALC1;
                        end
                    end
                end
                S_CALC1:  // target and measured are only read here on
                begin
                    ki_ff    <= qmul(kc_eff, ki_ff);
                    kd_ff    <= qmul(kc_eff, kd_ff);
                    mp_ff    <= qmul(gain_ff, err);
                    state_ff <= S_CALC2;
                end
                S_CALC2:
                begin
                    mi_ff    <= sat32(ext34(qmul(ki_ff, err)) + ext34(isum_ff));
                    md_ff    <= qmul(kd_ff, dmeas);
                    prev_ff  <= meas_ff;
                    state_ff <= S_CALC3;
                end
                S_CALC3:
                begin
                    out_ff    <= mn_clamp;
                    sat_hi_ff <= (mn_raw > ext34(`PID_ONE));
                    sat_lo_ff <= (mn_raw < 34'sh0);
                    // anti-windup: fold the overshoot back into the stored sum
                    if (!ti_inf)
                    begin
                        if (mn_raw > ext34(`PID_ONE))
                            isum_ff <= clamp01(ext34(`PID_ONE) - pd_sum);
                        else if (mn_raw < 34'sh0)
                            isum_ff <= clamp01(34'sh0 - pd_sum);
                        else
                            isum_ff <= clamp01(ext34(mi_ff));
                    end
                    scal_ff  <= mn_off * $signed({1'b0, span});
                    state_ff <= S_OUT;
                end
                S_OUT:
                begin
                    // round half up, keep the 32-bit integer's low half
                    ao_word  <= scal_rnd[31:16];
                    ao_valid <= 1'b1;
                    state_ff <= S_IDLE;
                end
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

endmodule // pid_loop

// File: pid_loop_consts.vh
// constants for the pid loop update block: offsets, fields, reset values, fixed-point figures
`ifndef PID_LOOP_CONSTS_VH
`define PID_LOOP_CONSTS_VH

// register byte offsets
`define PID_OFS_MEAS      8'h00
`define PID_OFS_TGT       8'h04
`define PID_OFS_OUT       8'h08
`define PID_OFS_GAIN      8'h0c
`define PID_OFS_TS        8'h10
`define PID_OFS_TI        8'h14
`define PID_OFS_TD        8'h18
`define PID_OFS_ISUM      8'h1c
`define PID_OFS_PREV      8'h20
`define PID_OFS_CTRL      8'h24
`define PID_OFS_STAT      8'h28
`define PID_OFS_RAW_MEAS  8'h2c
`define PID_OFS_RAW_TGT   8'h30
`define PID_OFS_AO        8'h34

// control field positions
`define PID_CTRL_EN       0
`define PID_CTRL_BIPOLAR  1
`define PID_CTRL_RUN      2
`define PID_CTRL_GO       3

// status field positions
`define PID_STAT_BUSY     0
`define PID_STAT_HIST     1
`define PID_STAT_FIRST    2
`define PID_STAT_EDGE     3
`define PID_STAT_SAT_HI   4
`define PID_STAT_SAT_LO   5

// reals are signed q16.16 fixed point
`define PID_ONE           32'sh0001_0000
`define PID_HALF          32'sh0000_8000
`define PID_ZERO          32'sh0000_0000
`define PID_INF           32'sh7fff_ffff
`define PID_RND           50'sh0_0000_0000_8000

// reset values and spans
`define PID_RST_REAL      32'h0000_0000
`define PID_RST_CTRL      3'h0
`define PID_UNI_SPAN      17'h0_7d00
`define PID_BI_SPAN       17'h0_fa00

// divider length: quotient bits of a q16.16 division
`define PID_DIV_BITS      6'h30
`endif

// File: pid_ao_model.sv
// analog output channel model: latches each new output word
`timescale 1ns/1ps
module pid_ao_model (
    input  wire        pclk,       // clock
    input  wire        presetn,    // async reset, active low
    input  wire [15:0] ao_word,    // word from the block
    input  wire        ao_valid,   // new word pulse
    output reg  [15:0] last_word,  // last latched word
    output reg  [31:0] word_count  // words taken so far
);
    // the channel takes a word only on the pulse, like a real converter latch
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_word  <= 16'h0000;
            word_count <= 32'h0000_0000;
        end
        else if (ao_valid)
        begin
            last_word  <= ao_word;
            word_count <= word_count + 32'h0000_0001;
        end
    end
endmodule // pid_ao_model

// File: pid_loop_chk.sv
// assertion checker for the pid loop block ports
`timescale 1ns/1ps
module pid_loop_chk #(
    parameter [16:0] UNI_SPAN = 17'h0_7d00,  // unipolar span
    parameter [16:0] BI_SPAN  = 17'h0_fa00   // bipolar span
) (
    input wire        pclk,     // clock
    input wire        presetn,  // async reset, active low
    input wire [7:0]  paddr,    // byte address
    input wire        psel,     // select
    input wire        penable,  // access phase
    input wire        pwrite,   // write
    input wire [31:0] pwdata,   // write data
    input wire [31:0] prdata,   // read data
    input wire        pready,   // ready
    input wire        pslverr,  // error
    input wire [15:0] ao_word,  // analog word
    input wire        ao_valid  // new word pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc; psel && penable; endsequence
    sequence s_rd; psel && penable && !pwrite; endsequence
    wire bad_addr = (paddr > 8'h34) || (paddr[1:0] != 2'b00);

    chk_unmapped_err: assert property (s_acc ##0 bad_addr |-> pslverr)
        else $error("unmapped access gave no error");
    chk_mapped_ok: assert property (s_acc ##0 !bad_addr |-> !pslverr)
        else $error("mapped access gave an error");
    chk_idle_quiet: assert property (!(psel && penable) |-> !pslverr && pready)
        else $error("error outside access or not ready");
    chk_unmapped_rd: assert property (s_rd ##0 pslverr |-> prdata == 32'h0000_0000)
        else $error("unmapped read data not zero");
    chk_go_rd_zero: assert property (s_rd ##0 (paddr == 8'h24) |-> !prdata[3])
        else $error("go bit read back as one");
    chk_raw_rd_zero: assert property (s_rd ##0 (paddr == 8'h2c || paddr == 8'h30) |-> prdata == 32'h0000_0000)
        else $error("raw register read not zero");
    chk_ao_pulse: assert property (ao_valid |=> !ao_valid)
        else $error("output pulse longer than one cycle");
    chk_ao_hold: assert property ($changed(ao_word) |-> ao_valid)
        else $error("output word changed without pulse");
    chk_ao_settle: assert property (ao_valid |=> $stable(ao_word) [*8])
        else $error("output word not held after update");
    chk_ao_range: assert property (ao_valid |-> int'($signed(ao_word)) <= int'(UNI_SPAN) &&
        int'($signed(ao_word)) >= -(int'(BI_SPAN) / 2))
        else $error("output word beyond scaled range");
endmodule // pid_loop_chk

bind pid_loop pid_loop_chk #(.UNI_SPAN(UNI_SPAN), .BI_SPAN(BI_SPAN)) pid_loop_chk_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ao_word(ao_word),
    .ao_valid(ao_valid));

// File: test_pid_loop.sv
// self-checking testbench for the pid loop update block
`timescale 1ns/1ps
`include "pid_loop_consts.vh"
module test_pid_loop;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h0, rd;
    reg         er;
    wire [31:0] prdata, wcnt;
    wire [15:0] ao_word, ao_last;
    wire        pready, pslverr, ao_valid;
    integer     err_count = 0, checks_done = 0;
    always #25 pclk = ~pclk;
    pid_loop pid_loop_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ao_word(ao_word), .ao_valid(ao_valid));
    pid_ao_model pid_ao_model_inst (.pclk(pclk), .presetn(presetn), .ao_word(ao_word), .ao_valid(ao_valid),
        .last_word(ao_last), .word_count(wcnt));
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task cmp32(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task cmp16(input [15:0] got, input [15:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0t output %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task idle;
        apb(`PID_OFS_STAT, 1'b0, 32'h0);
        while (rd[0] !== 1'b0)
            apb(`PID_OFS_STAT, 1'b0, 32'h0);
    endtask
    // software writes the loop fields directly; gain and times may lie outside 0..1
    task set_loop(input [31:0] tg, ms, g, ts, ti, td, is);
        wr(`PID_OFS_TGT, tg); wr(`PID_OFS_MEAS, ms); wr(`PID_OFS_GAIN, g);
        wr(`PID_OFS_TS, ts); wr(`PID_OFS_TI, ti); wr(`PID_OFS_TD, td);
        wr(`PID_OFS_ISUM, is);
    endtask
    task upd(input [31:0] ctl, input [31:0] eo, input [31:0] ei, input [15:0] ea);
        reg [31:0] n;
        n = wcnt;
        wr(`PID_OFS_CTRL, ctl);
        repeat (300) if (wcnt == n) @(posedge pclk);
        cmp32(wcnt, n + 32'h1);
        idle;
        apb(`PID_OFS_OUT, 1'b0, 0); cmp32(rd, eo);
        apb(`PID_OFS_ISUM, 1'b0, 0); cmp32(rd, ei);
        cmp16(ao_last, ea);
    endtask
    task t_reset;
        apb(`PID_OFS_OUT, 1'b0, 0); cmp32(rd, `PID_RST_REAL);
        apb(`PID_OFS_STAT, 1'b0, 0); cmp32(rd, 32'h6);
        apb(8'h38, 1'b0, 0); cmp32({er, rd[30:0]}, 32'h8000_0000);
    endtask
    task t_raw;
        wr(`PID_OFS_CTRL, 32'h4); wr(`PID_OFS_RAW_MEAS, 32'h3e80); idle;
        apb(`PID_OFS_MEAS, 1'b0, 0); cmp32(rd, 32'h8000);
        wr(`PID_OFS_CTRL, 32'h6); wr(`PID_OFS_RAW_TGT, 32'hc180); idle;
        apb(`PID_OFS_TGT, 1'b0, 0); cmp32(rd, 32'h4000);
    endtask
    task t_prop;
        wr(`PID_OFS_CTRL, 32'h4);
        set_loop(32'hc000, 32'h8000, `PID_ONE, `PID_ONE, `PID_INF, `PID_ONE, 32'h0);
        upd(32'hd, 32'h4000, 32'h0, 16'h1f40);
        apb(`PID_OFS_TGT, 1'b0, 0); cmp32(rd, 32'hc000);
        apb(`PID_OFS_PREV, 1'b0, 0); cmp32(rd, 32'h8000);
        wr(`PID_OFS_MEAS, 32'h6000);
        upd(32'hd, 32'h8000, 32'h0, 16'h3e80);
        apb(`PID_OFS_MEAS, 1'b0, 0); cmp32(rd, 32'h6000);
    endtask
    task t_clamp;
        set_loop(`PID_ONE, 32'h0, 32'h2_0000, `PID_ONE, `PID_ONE, 32'h0, 32'h0);
        upd(32'hd, `PID_ONE, 32'h0, 16'h7d00);
        set_loop(`PID_ONE, 32'h0, 32'hffff_0000, `PID_ONE, `PID_ONE, 32'h0, 32'h0);
        upd(32'hd, 32'h0, `PID_ONE, 16'h0000);
    endtask
    task t_zero_gain;
        set_loop(32'h8000, 32'h6000, 32'h0, `PID_ONE, `PID_ONE, 32'h0, 32'h0);
        upd(32'hd, 32'h2000, 32'h2000, 16'h0fa0);
        upd(32'hd, 32'h4000, 32'h4000, 16'h1f40);
        // negative integral time with zero gain: error now pulls the output down
        set_loop(32'h8000, 32'h6000, 32'h0, `PID_ONE, 32'hffff_0000, 32'h0, 32'h8000);
        upd(32'hd, 32'h6000, 32'h6000, 16'h2ee0);
    endtask
    task t_reverse;
        wr(`PID_OFS_CTRL, 32'h6);
        set_loop(32'h8000, 32'hc000, 32'hffff_0000, `PID_ONE, `PID_INF, 32'h0, 32'h8000);
        upd(32'hf, 32'hc000, 32'h8000, 16'h3e80);
    endtask
    task t_handover;
        wr(`PID_OFS_CTRL, 32'h4); wr(`PID_OFS_CTRL, 32'hc); idle;
        apb(`PID_OFS_STAT, 1'b0, 0); cmp32(rd & 32'h2, 32'h0);
        set_loop(32'hc000, 32'h8000, `PID_ONE, `PID_ONE, `PID_ONE, `PID_ONE, 32'h0);
        wr(`PID_OFS_OUT, 32'h4000);
        upd(32'hd, 32'h4000, 32'h4000, 16'h1f40);
        apb(`PID_OFS_TGT, 1'b0, 0); cmp32(rd, 32'h8000);
        apb(`PID_OFS_PREV, 1'b0, 0); cmp32(rd, 32'h8000);
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_reset; t_raw; t_prop; t_clamp; t_zero_gain; t_reverse; t_handover;
        give_verdict;
    end
    initial
    begin
        #(20000 * 50);
        err_count = err_count + 1;
        give_verdict;
    end
endmodule // test_pid_loop
